// *** src/crlcu_defs.vh ***
// Constants for the condition-logic, compare and leading-zero unit
`ifndef CRLCU_DEFS_VH
`define CRLCU_DEFS_VH
`define CRLCU_OP_CMPLI      6'd10
`define CRLCU_OP_XFORM      6'd31
`define CRLCU_OP_XLFORM     6'd19
`define CRLCU_XO_CLZ        10'd26
`define CRLCU_XO_AND        10'd257
`define CRLCU_XO_ANDC       10'd129
`define CRLCU_XO_NAND       10'd225
`define CRLCU_XO_OR         10'd449
`define CRLCU_XO_ORC        10'd417
`define CRLCU_XO_NOR        10'd33
`define CRLCU_XO_XOR        10'd193
`define CRLCU_XO_EQV        10'd289
`define CRLCU_ADDR_CR       4'h0
`define CRLCU_ADDR_XER      4'h4
`define CRLCU_ADDR_INSN     4'h8
`define CRLCU_ADDR_SRC      4'hc
`define CRLCU_CR_RESET      32'h00000000
`define CRLCU_RESP_OKAY     2'b00
`define CRLCU_RESP_SLVERR   2'b10
`endif

// *** src/crlcu_clz.v ***
// Leading-zero counter over a word numbered from the most significant bit
module crlcu_clz #(
    parameter W  = 32,
    parameter CW = 6
) (
    input  wire [W-1:0]  din,     // Word to scan
    output reg  [CW-1:0] count    // Leading zeros, 0 through W
);
    integer i;
    reg     found;
    // Scan downward from the top bit until the first one
    always @* begin
        count = W[CW-1:0];
        found = 1'b0;
        for (i = W - 1; i >= 0; i = i - 1) begin
            if (!found && din[i]) begin
                count = W[CW-1:0] - 1'b1 - i[CW-1:0];
                found = 1'b1;
            end
        end
    end
endmodule // crlcu_clz

// *** src/crlcu_unit.v ***
// Condition-logic, compare-immediate and leading-zero execution unit
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`include "crlcu_defs.vh"

// Operation
// - The compare-immediate operand is sixteen zero bits above the unsigned immediate.
// - Compare unsigned; result cleared, then bit 0 less, bit 1 greater, bit 2 equal.
// - Bit 3 of the compare result is the current summary-overflow flag.
// - Only the selected condition field takes the compare result.
// - Compare-immediate is opcode 10 with selector at bit 6 and immediate low.
// - Leading-zero count runs from the top bit and yields 0 through 32.
// - With the record bit set, field zero takes less, greater, equal and overflow.
// - Leading-zero count is opcode 31, extended opcode 26, source before target.
// - Single-bit condition operations are opcode 19 with three 5-bit selectors.
// - AND group: 257 AND, 129 AND-complement, 225 NAND.
// - OR group: 449 OR, 417 OR-complement, 33 NOR.
// - XOR group: 193 XOR, 289 equivalence.
// - No operation raises an exception, reserved bits notwithstanding.
module crlcu_unit (
    input  wire        aclk,           // Core clock, 40 MHz
    input  wire        aresetn,        // Synchronous reset, active low
    input  wire [3:0]  s_axi_awaddr,   // Write address
    input  wire        s_axi_awvalid,  // Write address valid
    output wire        s_axi_awready,  // Write address ready
    input  wire [31:0] s_axi_wdata,    // Write data
    input  wire [3:0]  s_axi_wstrb,    // Write byte enables
    input  wire        s_axi_wvalid,   // Write data valid
    output wire        s_axi_wready,   // Write data ready
    output reg  [1:0]  s_axi_bresp,    // Write response
    output reg         s_axi_bvalid,   // Write response valid
    input  wire        s_axi_bready,   // Write response ready
    input  wire [3:0]  s_axi_araddr,   // Read address
    input  wire        s_axi_arvalid,  // Read address valid
    output wire        s_axi_arready,  // Read address ready
    output reg  [31:0] s_axi_rdata,    // Read data
    output reg  [1:0]  s_axi_rresp,    // Read response
    output reg         s_axi_rvalid,   // Read data valid
    input  wire        s_axi_rready,   // Read data ready
    input  wire [31:0] insn,           // Instruction word from decoder
    input  wire        insn_valid,     // Instruction issue strobe
    input  wire [31:0] source_gpr,     // Source register contents
    output reg  [31:0] gpr_wdata,      // Leading-zero result
    output reg  [4:0]  gpr_waddr,      // Target register number
    output reg         gpr_we          // Target register write pulse
);
    reg  [31:0] cond_r;      // Condition register, bit 0 is the MSB
    reg         so_r;        // Summary-overflow flag
    reg         aw_got_r;    // Write address held
    reg         w_got_r;     // Write data held
    reg  [3:0]  aw_addr_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;
    reg  [31:0] last_insn_r; // Last issued instruction
    reg  [31:0] cond_nxt;
    reg  [31:0] src_word;
    reg         rd_ok;
    reg  [31:0] rd_data;

    // Apply byte enables to a stored word
    function [31:0] strb_merge;
        input [31:0] old;
        input [31:0] new_w;
        input [3:0]  strb;
        integer k;
        begin
            strb_merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (strb[k])
                    strb_merge[8*k +: 8] = new_w[8*k +: 8];
            end
        end
    endfunction

    // Read one condition bit by MSB-0 index
    function cond_bit;
        input [31:0] cr;
        input [4:0]  idx;
        begin
            cond_bit = cr[5'd31 - idx];
        end
    endfunction

    // Instruction fields
    wire [5:0]  opcode = insn[31:26];
    wire [2:0]  dest_field_selector = insn[25:23];
    wire [15:0] unsigned_immediate = insn[15:0];
    wire [4:0]  dest_cond_bit_sel = insn[25:21];
    wire [4:0]  first_cond_bit_sel = insn[20:16];
    wire [4:0]  second_cond_bit_sel = insn[15:11];
    wire [4:0]  clz_target = insn[20:16];
    wire [9:0]  ext_op = insn[10:1];
    wire        record_bit = insn[0];

    // Operands and compare
    wire [31:0] unsigned_immediate_ext = {16'h0000, unsigned_immediate};
    wire [3:0]  cmp_res = {(source_gpr < unsigned_immediate_ext), (source_gpr > unsigned_immediate_ext),
                           (source_gpr == unsigned_immediate_ext), so_r};
    wire [5:0]  lz_count;

    crlcu_clz #(
        .W  (32),
        .CW (6)
    ) u_clz (
        .din   (source_gpr),
        .count (lz_count)
    );

    wire [31:0] lz_word = {26'h0000000, lz_count};
    wire        lz_zero = (lz_word == 32'h00000000);
    wire        lz_neg = lz_word[31];
    wire [3:0]  lz_flags = {lz_neg, ~lz_neg & ~lz_zero, lz_zero, so_r};
    wire        bit_a = cond_bit(cond_r, first_cond_bit_sel);
    wire        bit_b = cond_bit(cond_r, second_cond_bit_sel);

    // Issue decode; no branch raises a fault
    wire is_cmpli = insn_valid && (opcode == `CRLCU_OP_CMPLI);
    wire is_clz = insn_valid && (opcode == `CRLCU_OP_XFORM) && (ext_op == `CRLCU_XO_CLZ);
    wire is_crl = insn_valid && (opcode == `CRLCU_OP_XLFORM);

    // Single-bit logic result
    reg crl_res;
    reg crl_hit;
    always @* begin
        crl_hit = 1'b1;
        case (ext_op)
            `CRLCU_XO_AND:  crl_res = bit_a & bit_b;
            `CRLCU_XO_ANDC: crl_res = bit_a & ~bit_b;
            `CRLCU_XO_NAND: crl_res = ~(bit_a & bit_b);
            `CRLCU_XO_OR:   crl_res = bit_a | bit_b;
            `CRLCU_XO_ORC:  crl_res = bit_a | ~bit_b;
            `CRLCU_XO_NOR:  crl_res = ~(bit_a | bit_b);
            `CRLCU_XO_XOR:  crl_res = bit_a ^ bit_b;
            `CRLCU_XO_EQV:  crl_res = ~(bit_a ^ bit_b);
            default: begin
                crl_res = 1'b0;
                crl_hit = 1'b0; // Other opcodes leave the register alone
            end
        endcase
    end

    // AXI write channel handshakes and read address ready
    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready = !w_got_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire wr_fire = (aw_got_r || (s_axi_awvalid && s_axi_awready)) &&
                   (w_got_r || (s_axi_wvalid && s_axi_wready));
    wire [3:0]  wr_addr = aw_got_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_got_r ? w_data_r : s_axi_wdata;
    wire [3:0]  wr_strb = w_got_r ? w_strb_r : s_axi_wstrb;
    wire wr_cr = wr_fire && (wr_addr == `CRLCU_ADDR_CR);

    // One compare-write enable per condition field, field 0 at the top
    wire [7:0] field_hit;
    genvar f;
    generate
        for (f = 0; f < 8; f = f + 1) begin : g_field
            localparam [2:0] FSEL = f;
            assign field_hit[f] = is_cmpli && (dest_field_selector == FSEL);
        end
    endgenerate

    // Next condition register; instruction updates win over a bus write
    integer fi;
    always @* begin
        cond_nxt = wr_cr ? strb_merge(cond_r, wr_data, wr_strb) : cond_r;
        for (fi = 0; fi < 8; fi = fi + 1) begin
            if (field_hit[fi])
                cond_nxt[31 - 4 * fi -: 4] = cmp_res;
        end
        if (is_clz && record_bit)
            cond_nxt[31:28] = lz_flags;
        else if (is_crl && crl_hit)
            cond_nxt[5'd31 - dest_cond_bit_sel] = crl_res;
    end

    // Condition register
    always @(posedge aclk) begin
        if (!aresetn) begin
            cond_r <= `CRLCU_CR_RESET;
        end else begin
            cond_r <= cond_nxt;
        end
    end

    // Last issued instruction, kept for software to inspect
    always @(posedge aclk) begin
        if (!aresetn) begin
            last_insn_r <= 32'h00000000;
        end else if (insn_valid) begin
            last_insn_r <= insn;
        end
    end

    // Summary-overflow flag, set or cleared only through its own offset
    always @(posedge aclk) begin
        if (!aresetn) begin
            so_r <= 1'b0;
        end else if (wr_fire && (wr_addr == `CRLCU_ADDR_XER) && wr_strb[3]) begin
            so_r <= wr_data[31];
        end
    end

    // Write address and data are held until both halves have arrived
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end else if (wr_fire) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
        end
    end

    // Write response; only the two writable offsets answer OKAY
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CRLCU_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_addr == `CRLCU_ADDR_CR || wr_addr == `CRLCU_ADDR_XER) ?
                           `CRLCU_RESP_OKAY : `CRLCU_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read decode
    always @* begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `CRLCU_ADDR_CR:   rd_data = cond_r;
            `CRLCU_ADDR_XER:  rd_data = {so_r, 31'h00000000};
            `CRLCU_ADDR_INSN: rd_data = last_insn_r;
            `CRLCU_ADDR_SRC:  rd_data = src_word;
            default: begin
                rd_data = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end

    // Read response, one read outstanding at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CRLCU_RESP_OKAY;
        end else begin
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_ok ? `CRLCU_RESP_OKAY : `CRLCU_RESP_SLVERR;
            end
        end
    end

    // Leading-zero writeback; result and target stand until the next count
    always @(posedge aclk) begin
        if (!aresetn) begin
            gpr_we <= 1'b0;
            gpr_waddr <= 5'h00;
            gpr_wdata <= 32'h00000000;
        end else begin
            gpr_we <= is_clz;
            if (is_clz) begin
                gpr_waddr <= clz_target;
                gpr_wdata <= lz_word;
            end
        end
    end

    // Last source operand, kept for software to inspect
    always @(posedge aclk) begin
        if (!aresetn) begin
            src_word <= 32'h00000000;
        end else if (insn_valid) begin
            src_word <= source_gpr;
        end
    end
endmodule // crlcu_unit

// *** tb/crlcu_assertions.sv ***
// Checker for the leading-zero write-back of the execution unit
`include "crlcu_defs.vh"
module crlcu_assertions (
    input wire        aclk,       // Core clock
    input wire        aresetn,    // Sync reset, active low
    input wire [31:0] insn,       // Issued word
    input wire        insn_valid, // Issue strobe
    input wire [31:0] source_gpr, // Operand
    input wire [31:0] gpr_wdata,  // Count
    input wire [4:0]  gpr_waddr,  // Target
    input wire        gpr_we      // Write pulse
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Leading-zero issue and its target field
    wire       clz_go = insn_valid && insn[31:26] == `CRLCU_OP_XFORM
                        && insn[10:1] == `CRLCU_XO_CLZ;
    wire [4:0] tgt    = insn[20:16];
    // Reference count from the top bit down
    function automatic [5:0] lead0(input [31:0] v);
        integer k;
        begin
            lead0 = 6'h20;
            for (k = 0; k < 32; k = k + 1)
                if (v[k]) lead0 = 6'(31 - k);
        end
    endfunction
    chk_clz_pulse: assert property (clz_go |=> gpr_we)
        else $error("count not written");
    chk_no_stray: assert property (!clz_go |=> !gpr_we)
        else $error("stray register write");
    chk_clz_target: assert property (clz_go |=> gpr_waddr == $past(tgt))
        else $error("wrong target");
    chk_clz_count: assert property (clz_go |=> gpr_wdata == {26'h0, lead0($past(source_gpr))})
        else $error("wrong count");
    chk_zero_word: assert property (clz_go && source_gpr == 32'h0 |=> gpr_wdata == 32'h20)
        else $error("zero word not 32");
    chk_top_set: assert property (clz_go && source_gpr[31] |=> gpr_wdata == 32'h0)
        else $error("top bit set not 0");
    chk_count_range: assert property (gpr_we |-> gpr_wdata <= 32'h20)
        else $error("count above 32");
    chk_result_hold: assert property (!gpr_we |-> $stable(gpr_wdata) && $stable(gpr_waddr))
        else $error("result moved");
    cover property (clz_go ##1 gpr_we);
    cover property (insn_valid && insn[31:26] == `CRLCU_OP_CMPLI);
    cover property (insn_valid && insn[31:26] == `CRLCU_OP_XLFORM);
endmodule // crlcu_assertions
bind crlcu_unit crlcu_assertions i_chk (.aclk, .aresetn, .insn, .insn_valid, .source_gpr,
    .gpr_wdata, .gpr_waddr, .gpr_we);

// *** tb/crlcu_decoder_model.sv ***
// Decoder and register-file model on the far side of the unit
module crlcu_decoder_model (
    input  wire         aclk,       // Core clock
    output logic [31:0] insn,       // Issued word
    output logic        insn_valid, // Issue strobe
    output logic [31:0] source_gpr, // Operand
    input  wire         gpr_we,     // Write pulse
    input  wire  [4:0]  gpr_waddr,  // Target
    input  wire  [31:0] gpr_wdata   // Count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] q[$];   // Pending word and operand pairs
    logic [31:0] rf[32]; // Register file
    initial begin
        insn = 32'h0;
        insn_valid = 1'b0;
        source_gpr = 32'h0;
    end
    // One issue per cycle; the operand bus scrambles when idle
    always @(posedge aclk) begin
        if (q.size() != 0) begin
            {insn, source_gpr} <= q.pop_front();
            insn_valid <= 1'b1;
        end else begin
            insn_valid <= 1'b0;
            source_gpr <= ~source_gpr;
        end
    end
    // Capture write-backs
    always @(posedge aclk)
        if (gpr_we) rf[gpr_waddr] <= gpr_wdata;
endmodule // crlcu_decoder_model

// *** tb/tb.sv ***
// Bench for the condition-logic execution unit
`include "crlcu_defs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, insn, source_gpr, gpr_wdata, ec, got;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        insn_valid, gpr_we;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [4:0]  gpr_waddr;
    logic [2:0]  cf[3] = '{3'h1, 3'h6, 3'h7};
    logic [31:0] ca[3] = '{32'hffff8000, 32'h3, 32'habcd};
    logic [15:0] cm[3] = '{16'h8000, 16'h4, 16'habcd};
    logic [3:0]  cn[3] = '{4'h5, 4'h9, 4'h2};
    logic [31:0] zs[4] = '{32'h80000000, 32'h1, 32'h10000, 32'h0};
    logic [31:0] zc[4] = '{32'h0, 32'h1f, 32'hf, 32'h20};
    logic [9:0]  xt[8] = '{10'h101, 10'h081, 10'h0e1, 10'h1c1, 10'h1a1, 10'h021, 10'h0c1, 10'h121};
    int          num_errors = 0, checked = 0, i, j;
    crlcu_unit i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .insn, .insn_valid, .source_gpr,
        .gpr_wdata, .gpr_waddr, .gpr_we);
    crlcu_decoder_model i_dec (.aclk, .insn, .insn_valid, .source_gpr, .gpr_we, .gpr_waddr,
        .gpr_wdata);
    // 40 MHz clock
    always #12.5 aclk = ~aclk;
    task automatic results;
        $display("Checks %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] g, e);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stall(input int n);
        if (n >= 64) begin
            num_errors++;
            $display("ERROR wait expected answer seen none");
            results;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        stall(n);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        stall(n);
        got = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic settle;
        int n;
        for (n = 0; n < 64 && i_dec.q.size() != 0; n++) @(posedge aclk);
        stall(n);
        repeat (3) @(posedge aclk);
    endtask
    // Truth of one condition-bit operation
    function automatic logic lop(input logic [9:0] x, input logic a, b);
        case (x)
            10'h101: lop = a & b;
            10'h081: lop = a & ~b;
            10'h0e1: lop = ~(a & b);
            10'h1c1: lop = a | b;
            10'h1a1: lop = a | ~b;
            10'h021: lop = ~(a | b);
            10'h0c1: lop = a ^ b;
            default: lop = ~(a ^ b);
        endcase
    endfunction
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset values and an unmapped offset
        rd(`CRLCU_ADDR_CR);
        check("cr_reset", got, `CRLCU_CR_RESET);
        rd(`CRLCU_ADDR_XER);
        check("ovf_reset", got, 32'h0);
        rd(4'h2);
        check("unmapped", {30'h0, resp}, {30'h0, `CRLCU_RESP_SLVERR});
        wr(`CRLCU_ADDR_INSN, 32'h1);
        check("ro_write", {30'h0, resp}, {30'h0, `CRLCU_RESP_SLVERR});
        $display("Test reset: done");
        // Unsigned compares into three fields, reserved bits set
        ec = 32'hffffffff;
        wr(`CRLCU_ADDR_CR, ec);
        for (j = 0; j < 3; j++) begin
            wr(`CRLCU_ADDR_XER, {j < 2, 31'h0});
            i_dec.q.push_back({`CRLCU_OP_CMPLI, cf[j], 2'b11, 5'h3, cm[j], ca[j]});
            settle;
            ec[31 - 4 * cf[j] -: 4] = cn[j];
        end
        rd(`CRLCU_ADDR_CR);
        check("cmp_fields", got, ec);
        rd(`CRLCU_ADDR_SRC);
        check("last_src", got, 32'habcd);
        $display("Test compare: done");
        // Back-to-back counts with the record bit set
        wr(`CRLCU_ADDR_XER, 32'h80000000);
        for (j = 0; j < 4; j++)
            i_dec.q.push_back({`CRLCU_OP_XFORM, 5'h9, 5'(j + 1), 5'h1f, `CRLCU_XO_CLZ, 1'b1,
                zs[j]});
        settle;
        for (j = 0; j < 4; j++) check("clz_count", i_dec.rf[j + 1], zc[j]);
        ec[31:28] = 4'h5;
        rd(`CRLCU_ADDR_CR);
        check("clz_record", got, ec);
        $display("Test count: done");
        // Each bit operation over all four input pairs
        for (j = 0; j < 8; j++) begin
            wr(`CRLCU_ADDR_CR, 32'h35000000);
            for (i = 0; i < 4; i++)
                i_dec.q.push_back({`CRLCU_OP_XLFORM, 5'(8 + i), 5'(i), 5'(4 + i), xt[j], 33'h0});
            settle;
            rd(`CRLCU_ADDR_CR);
            check("bit_op", got, {8'h35, lop(xt[j], 1'b0, 1'b0), lop(xt[j], 1'b0, 1'b1),
                lop(xt[j], 1'b1, 1'b0), lop(xt[j], 1'b1, 1'b1), 20'h0});
        end
        rd(`CRLCU_ADDR_INSN);
        check("last_insn", got, {`CRLCU_OP_XLFORM, 15'h2c67, 10'h121, 1'b0});
        $display("Test logic: done");
        results;
    end
endmodule // tb
